// ===== pmu_defs.svh
// constants of the unit performance monitor: field positions, offsets, resets
// assumes inclusion by bare name from every design file that needs them
`ifndef PMU_DEFS_SVH
`define PMU_DEFS_SVH

// unit control fields
`define PMU_UCTL_FRZ 8
`define PMU_UCTL_RST_CTRS 1
`define PMU_UCTL_RST_CTRL 0

// counter control fields
`define PMU_CTL_THR_LO 24
`define PMU_CTL_THR_HI 31
`define PMU_CTL_INVERT 23
`define PMU_CTL_EN 22
`define PMU_CTL_NOTIFY 20
`define PMU_CTL_EDGE 18
`define PMU_CTL_CLR 17
`define PMU_CTL_UMASK_LO 8
`define PMU_CTL_UMASK_HI 15
`define PMU_CTL_EVSEL_LO 0
`define PMU_CTL_EVSEL_HI 7
`define PMU_CTL_RW_MASK 32'hffd4ffff

// counter data
`define PMU_CTR_W 48
`define PMU_CTR_PAD 16'h0000
`define PMU_CTR_ALL_ONES 48'hffffffffffff

// reset values
`define PMU_RST_CTL 32'h00000000
`define PMU_RST_CTR 48'h000000000000
`define PMU_RST_WORD 64'h0000000000000000

// register index map
`define PMU_ADDR_UCTL 8'h00
`define PMU_ADDR_USTAT 8'h01
`define PMU_ADDR_CTL_BASE 8'h10
`define PMU_ADDR_CTR_BASE 8'h20

// subevent lanes per event
`define PMU_SUBEVENTS 8

`endif

// ===== pmu_pkg.sv
// types shared by the unit performance monitor files
// assumes nothing of its surroundings
`default_nettype none
package pmu_pkg;
    typedef logic [47:0] pmu_count_t;
    typedef logic [31:0] pmu_ctl_t;
    typedef logic [63:0] pmu_word_t;
    typedef logic [7:0] pmu_addr_t;
    typedef logic [7:0] pmu_byte_t;
endpackage
`default_nettype wire

// ===== pmu_counter.sv
// one counter with its event shaping: subevent sum, threshold, invert, edge
// assumes event increments come from logic on the same clock
`include "pmu_defs.svh"
`default_nettype none
module pmu_counter #(
    parameter int EVENTS = 8,
    parameter int INC_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [EVENTS*`PMU_SUBEVENTS*INC_W-1:0] event_inc,
    input wire pmu_pkg::pmu_ctl_t ctl,
    input wire logic freeze,
    input wire logic clr,
    input wire logic wr,
    input wire pmu_pkg::pmu_count_t wdata,
    output logic [`PMU_CTR_W-1:0] value,
    output logic ovf
);
    import pmu_pkg::*;
    localparam int SUM_W = INC_W + 3;

    logic [SUM_W-1:0] inc;
    logic prev_qual;
    pmu_byte_t thresh, evsel, umask;
    logic invert, edge_mode, thr_on, cmp, qual, edge_hit, run;
    logic [`PMU_CTR_W-1:0] step;
    logic [`PMU_CTR_W:0] sum;
    pmu_count_t next_value;

    assign thresh = ctl[`PMU_CTL_THR_HI:`PMU_CTL_THR_LO];
    assign umask = ctl[`PMU_CTL_UMASK_HI:`PMU_CTL_UMASK_LO];
    assign evsel = ctl[`PMU_CTL_EVSEL_HI:`PMU_CTL_EVSEL_LO];
    assign invert = ctl[`PMU_CTL_INVERT];
    assign edge_mode = ctl[`PMU_CTL_EDGE];

    always_comb begin
        inc = '0;
        for (int s = 0; s < `PMU_SUBEVENTS; s++) begin
            if (umask[s] && int'(evsel) < EVENTS) begin
                inc = inc + SUM_W'(event_inc[(int'(evsel) * `PMU_SUBEVENTS + s) * INC_W +: INC_W]);
            end
        end
    end

    assign thr_on = thresh != 8'h00;
    assign cmp = invert ? (SUM_W'(thresh) > inc) : (inc >= SUM_W'(thresh));
    // with a zero level the edge stage sees any activity as one
    assign qual = thr_on ? cmp : (inc != '0);
    assign edge_hit = invert ? (prev_qual & ~qual) : (~prev_qual & qual);
    assign step = edge_mode ? `PMU_CTR_W'(edge_hit) :
                  thr_on ? `PMU_CTR_W'(cmp) : `PMU_CTR_W'(inc);
    assign run = ctl[`PMU_CTL_EN] & ~freeze;
    assign sum = {1'b0, value} + {1'b0, step};
    // the carry leaves on ovf while the stored count wraps and keeps going
    assign next_value = clr ? `PMU_RST_CTR : wr ? wdata : run ? sum[`PMU_CTR_W-1:0] : value;
    assign ovf = ~clr & ~wr & run & sum[`PMU_CTR_W];

    always_ff @(posedge clk) begin
        if (srst) begin
            value <= `PMU_RST_CTR;
            prev_qual <= 1'b0;
        end else begin
            value <= next_value;
            prev_qual <= qual;
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (srst);

    a_carry_flag: assert property (run && !clr && !wr && value == `PMU_CTR_ALL_ONES && step != '0 |-> ovf)
        else $error("carry out of bit 47 not flagged");
    // a large step can overflow from below all ones, so the wrapped value is the truncated sum
    a_wrap_keeps: assert property (ovf |=> value == `PMU_CTR_W'($past(value) + $past(step)))
        else $error("counter did not wrap past zero");
    a_clear_one: assert property (clr |=> value == `PMU_RST_CTR)
        else $error("cleared counter not zero");
    a_thresh_unit: assert property (thr_on && !edge_mode |-> step <= 48'h1)
        else $error("thresholded step above one");
    a_edge_single: assert property (edge_mode && run && !clr && !wr && step != '0 |=> step == '0)
        else $error("edge mode counted two cycles in a row");
    a_gate_hold: assert property (!run && !clr && !wr |=> $stable(value))
        else $error("counter moved while gated");
endmodule
`default_nettype wire

// ===== pmu_unit.sv
// unit performance monitor: unit control, wrap status, counter pairs, hub message
// assumes a same-clock register port and a same-clock hub (freeze in, message out)
`include "pmu_defs.svh"
`default_nettype none
module pmu_unit #(
    parameter int PAIRS = 4,
    parameter int EVENTS = 8,
    parameter int INC_W = 8,
    parameter int UNIT_W = 8,
    parameter logic [UNIT_W-1:0] UNIT_ID = 8'h02
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire pmu_pkg::pmu_addr_t REG_ADDR,
    input wire pmu_pkg::pmu_word_t REG_WDATA,
    output pmu_pkg::pmu_word_t REG_RDATA,
    output logic REG_RVALID,
    input wire logic [EVENTS*`PMU_SUBEVENTS*INC_W-1:0] EVENT_INC,
    input wire logic GLOBAL_FREEZE,
    output logic OVF_MSG,
    output logic [UNIT_W-1:0] OVF_UNIT,
    output logic UNIT_FROZEN
);
    import pmu_pkg::*;
    localparam int IDX_W = PAIRS > 1 ? $clog2(PAIRS) : 1;

    function automatic logic pair_hit(input pmu_addr_t addr, input pmu_addr_t base);
        pair_hit = (addr >= base) && (int'(addr - base) < PAIRS);
    endfunction

    function automatic logic [IDX_W-1:0] pair_idx(input pmu_addr_t addr, input pmu_addr_t base);
        pmu_addr_t d;
        d = addr - base;
        pair_idx = d[IDX_W-1:0];
    endfunction

    // register selection
    logic sel_uctl, sel_ustat, hit_ctl, hit_ctr;
    logic [IDX_W-1:0] idx_ctl, idx_ctr;
    logic wr_uctl, wr_ustat, rst_ctrs, rst_ctrl, freeze;

    assign sel_uctl = REG_ADDR == `PMU_ADDR_UCTL;
    assign sel_ustat = REG_ADDR == `PMU_ADDR_USTAT;
    assign hit_ctl = pair_hit(REG_ADDR, `PMU_ADDR_CTL_BASE);
    assign hit_ctr = pair_hit(REG_ADDR, `PMU_ADDR_CTR_BASE);
    assign idx_ctl = pair_idx(REG_ADDR, `PMU_ADDR_CTL_BASE);
    assign idx_ctr = pair_idx(REG_ADDR, `PMU_ADDR_CTR_BASE);
    assign wr_uctl = REG_WR & sel_uctl;
    assign wr_ustat = REG_WR & sel_ustat;
    // bits 17:16 are taken as written; only the three live bits act
    assign rst_ctrs = wr_uctl & REG_WDATA[`PMU_UCTL_RST_CTRS];
    assign rst_ctrl = wr_uctl & REG_WDATA[`PMU_UCTL_RST_CTRL];

    logic frz;
    assign freeze = frz | GLOBAL_FREEZE;

    // counter pairs
    pmu_ctl_t ctl [PAIRS];
    pmu_ctl_t next_ctl [PAIRS];
    logic [`PMU_CTR_W-1:0] ctr_val [PAIRS];
    logic [PAIRS-1:0] ctl_wr, ctr_wr, ctr_clr, ovf, notify, w1c;
    logic [PAIRS-1:0] status, next_status, msg_req;

    genvar g;
    generate
        for (g = 0; g < PAIRS; g++) begin : g_pair
            assign ctl_wr[g] = REG_WR & hit_ctl & (idx_ctl == IDX_W'(g));
            assign ctr_wr[g] = REG_WR & hit_ctr & (idx_ctr == IDX_W'(g));
            assign ctr_clr[g] = rst_ctrs | (ctl_wr[g] & REG_WDATA[`PMU_CTL_CLR]);
            // reserved and write-only control bits are never stored
            assign next_ctl[g] = rst_ctrl ? `PMU_RST_CTL :
                                 ctl_wr[g] ? (REG_WDATA[31:0] & `PMU_CTL_RW_MASK) : ctl[g];
            assign notify[g] = ctl[g][`PMU_CTL_NOTIFY];
            assign w1c[g] = wr_ustat & REG_WDATA[g];
            // only a fresh wrap notifies, so a standing flag blocks refreezing
            assign msg_req[g] = ovf[g] & notify[g] & ~status[g];

            pmu_counter #(
                .EVENTS(EVENTS),
                .INC_W(INC_W)
            ) u_ctr (
                .clk(CLOCK),
                .srst(SRST),
                .event_inc(EVENT_INC),
                .ctl(ctl[g]),
                .freeze(freeze),
                .clr(ctr_clr[g]),
                .wr(ctr_wr[g]),
                .wdata(REG_WDATA[`PMU_CTR_W-1:0]),
                .value(ctr_val[g]),
                .ovf(ovf[g])
            );
        end
    endgenerate

    // a wrap in the clearing cycle survives the clear
    assign next_status = (status & ~w1c) | ovf;

    // read selection
    pmu_word_t rd_mux;
    assign rd_mux = sel_ustat ? 64'(status) :
                    hit_ctl ? {32'h00000000, ctl[idx_ctl]} :
                    hit_ctr ? {`PMU_CTR_PAD, ctr_val[idx_ctr]} :
                    `PMU_RST_WORD;

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            frz <= 1'b0;
        end else if (wr_uctl) begin
            frz <= REG_WDATA[`PMU_UCTL_FRZ];
        end
    end

    always_ff @(posedge CLOCK) begin
        for (int i = 0; i < PAIRS; i++) begin
            ctl[i] <= SRST ? `PMU_RST_CTL : next_ctl[i];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            OVF_MSG <= 1'b0;
            OVF_UNIT <= '0;
        end else begin
            OVF_MSG <= |msg_req;
            OVF_UNIT <= UNIT_ID;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            REG_RDATA <= `PMU_RST_WORD;
            REG_RVALID <= 1'b0;
            UNIT_FROZEN <= 1'b0;
        end else begin
            REG_RDATA <= REG_RD ? rd_mux : `PMU_RST_WORD;
            REG_RVALID <= REG_RD;
            UNIT_FROZEN <= freeze;
        end
    end

    default clocking dc @(posedge CLOCK); endclocking
    default disable iff (SRST);

    a_unit_freeze: assert property (frz && !REG_WR |=> $stable(ctr_val[0]))
        else $error("counter moved under unit freeze");
    a_global_freeze: assert property (GLOBAL_FREEZE && !REG_WR |=> $stable(ctr_val[0]))
        else $error("counter moved under global freeze");
    a_clear_counts: assert property (rst_ctrs |=> ctr_val[PAIRS-1] == `PMU_RST_CTR)
        else $error("clear counters left a value");
    a_clear_ctls: assert property (rst_ctrl |=> ctl[PAIRS-1] == `PMU_RST_CTL ##1 !ovf[PAIRS-1])
        else $error("clear controls left a control");
    a_wrap_sets: assert property (ovf[0] |=> status[0])
        else $error("overflow did not set its flag");
    a_flag_sticky: assert property (status[0] && !w1c[0] |=> status[0])
        else $error("wrap flag dropped without a write");
    a_flag_clear: assert property (w1c[0] && !ovf[0] |=> !status[0])
        else $error("write one did not clear flag");
    a_msg_cause: assert property (OVF_MSG |-> $past(ovf & notify & ~status) != '0)
        else $error("message without a fresh notified wrap");
    a_msg_sent: assert property (ovf[0] && notify[0] && !status[0] |=> OVF_MSG && OVF_UNIT == UNIT_ID)
        else $error("notified wrap sent no message");
    a_no_remsg: assert property (status == '1 |=> !OVF_MSG)
        else $error("message while every flag stands");
    a_high_zero: assert property (REG_RVALID |-> REG_RDATA[63:48] == `PMU_CTR_PAD)
        else $error("reserved counter bits read nonzero");
    a_read_one: assert property (REG_RD |=> REG_RVALID ##1 (REG_RVALID == $past(REG_RD)))
        else $error("read answer not one cycle later");

    c_overflow: cover property (ovf[0] ##1 status[0]);
    c_message: cover property (OVF_MSG ##[1:20] GLOBAL_FREEZE);
    c_refreeze: cover property (w1c[0] ##[1:50] OVF_MSG);
endmodule
`default_nettype wire

// ===== pmu_hub_model.sv
// behavioural hub: records overflow messages and drives the global freeze
// assumes the unit's message pulse and the freeze share one clock
`default_nettype none
module pmu_hub_model #(
    parameter int UNIT_W = 8
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic msg,
    input wire logic [UNIT_W-1:0] unit,
    input wire logic clr,
    output logic freeze,
    output logic flag,
    output logic [UNIT_W-1:0] who,
    output int n_msgs
);
    timeunit 1ns;
    timeprecision 1ps;
    // freeze stands as long as the flag, so a second freeze needs the flag cleared first
    assign freeze = flag;
    always_ff @(posedge clk) begin
        if (srst) begin
            flag <= 1'b0;
            who <= '0;
            n_msgs <= 0;
        end else if (msg) begin
            flag <= 1'b1;
            who <= unit;
            n_msgs <= n_msgs + 1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== perf_monitor_unit_tb_top.sv
// self-checking bench of the unit monitor with the behavioural hub beside it
// assumes register port, events and hub all on one 250 MHz clock
`include "pmu_defs.svh"
`default_nettype none
module perf_monitor_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pmu_pkg::*;
    typedef struct {pmu_ctl_t ctl; pmu_byte_t inc; pmu_word_t exp;} pmu_row_t;
    localparam pmu_addr_t UC = `PMU_ADDR_UCTL;
    localparam pmu_addr_t US = `PMU_ADDR_USTAT;
    localparam pmu_addr_t CL = `PMU_ADDR_CTL_BASE;
    localparam pmu_addr_t CT = `PMU_ADDR_CTR_BASE;
    localparam pmu_word_t ONES48 = 64'h0000ffffffffffff;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    pmu_addr_t reg_addr = '0;
    pmu_word_t reg_wdata = '0;
    pmu_word_t reg_rdata;
    pmu_word_t got;
    logic reg_rvalid, frz, ovf_msg, unit_frozen, hub_flag;
    logic [511:0] ev = '0;
    logic hub_clr = 1'b0;
    logic [7:0] ovf_unit, hub_who;
    int hub_n;
    int num_errors = 0;
    int n_compared = 0;
    // four counting edges per row; every row drives event 0, subevent 0, but row 8 selects no subevent and row 9 selects event 1
    pmu_row_t rows [10] = '{'{32'h00400100, 8'h03, 64'hc}, '{32'h03400100, 8'h03, 64'h4},
        '{32'h04400100, 8'h03, 64'h0}, '{32'h04c00100, 8'h03, 64'h4}, '{32'h04c00100, 8'h04, 64'h0},
        '{32'h00000100, 8'h03, 64'h0}, '{32'h01440100, 8'h03, 64'h1}, '{32'h01c40100, 8'h03, 64'h1},
        '{32'h00400000, 8'h03, 64'h0}, '{32'h00400101, 8'h03, 64'h0}};
    pmu_unit u_dut (.CLOCK(clock), .SRST(srst), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .EVENT_INC(ev),
        .GLOBAL_FREEZE(frz), .OVF_MSG(ovf_msg), .OVF_UNIT(ovf_unit), .UNIT_FROZEN(unit_frozen));
    pmu_hub_model u_hub (.clk(clock), .srst(srst), .msg(ovf_msg), .unit(ovf_unit), .clr(hub_clr),
        .freeze(frz), .flag(hub_flag), .who(hub_who), .n_msgs(hub_n));
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic chk(input pmu_word_t seen, input pmu_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input pmu_addr_t a, input pmu_word_t d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // the answer stands one cycle, so it is looked at just after the edge that raised it
    task automatic rc(input pmu_addr_t a, input pmu_word_t e);
        int k;
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        for (k = 0; k < 4 && reg_rvalid !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        if (k == 4) begin
            num_errors++;
            close_out();
        end else begin
            chk(reg_rdata, e);
        end
    endtask
    initial begin
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        rc(US, 64'h0);
        rc(UC, 64'h0);
        rc(CL, 64'h0);
        rc(CT, 64'h0);
        rc(8'h05, 64'h0);
        chk({56'h0, ovf_unit}, 64'h2);
        wr(CL + 8'h1, '1);
        rc(CL + 8'h1, 64'hffd4ffff);
        wr(CT + 8'h2, '1);
        rc(CT + 8'h2, ONES48);
        wr(CL + 8'h1, 64'h20000);
        rc(CL + 8'h1, 64'h0);
        rc(CT + 8'h1, 64'h0);
        rc(CT + 8'h2, ONES48);
        wr(UC, 64'h30002);
        rc(CT + 8'h2, 64'h0);
        wr(CL + 8'h2, 64'h00400100);
        wr(UC, 64'h30001);
        rc(CL + 8'h2, 64'h0);
        wr(UC, 64'h30100);
        for (int i = 0; i < 10; i++) begin
            wr(CL, {32'h0, rows[i].ctl});
            wr(CT, 64'h0);
            wr(UC, 64'h30000);
            ev[7:0] <= rows[i].inc;
            repeat (2) @(posedge clock);
            wr(UC, 64'h30100);
            ev <= '0;
            rc(CT, rows[i].exp);
        end
        wr(CL, 64'h00400100);
        wr(CT, 64'h0);
        ev[7:0] <= 8'h03;
        repeat (4) @(posedge clock);
        ev <= '0;
        #1;
        chk({63'h0, unit_frozen}, 64'h1);
        rc(CT, 64'h0);
        wr(CL, 64'h00500100);
        wr(CT, 64'hfffffffffffe);
        wr(UC, 64'h30000);
        ev[7:0] <= 8'h01;
        repeat (8) @(posedge clock);
        ev <= '0;
        rc(CT, 64'h1);
        chk({63'h0, hub_flag}, 64'h1);
        chk({56'h0, hub_who}, 64'h2);
        chk(64'(hub_n), 64'h1);
        chk({63'h0, unit_frozen}, 64'h1);
        rc(US, 64'h1);
        rc(US, 64'h1);
        wr(US, 64'h1);
        rc(US, 64'h0);
        @(posedge clock);
        hub_clr <= 1'b1;
        @(posedge clock);
        hub_clr <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk({63'h0, unit_frozen}, 64'h0);
        close_out();
    end
endmodule
`default_nettype wire
